/* pwk_pkg.sv */
// constants, register map and state type of the power state and wake block
// assumes a 40 MHz device clock and a 32-bit word register port
package pwk_pkg;

    // device clock and derived timing
    localparam int unsigned PWK_CLK_HZ = 40_000_000;
    localparam int unsigned PWK_WAKE_READY_MS = 2;
    // longest time: rounded down to whole cycles
    localparam int unsigned PWK_WAKE_READY_CYC =
        PWK_WAKE_READY_MS * (PWK_CLK_HZ / 1000);
    localparam int unsigned PWK_EVENT_PULSE_MS = 50;
    localparam int unsigned PWK_EVENT_PULSE_CYC =
        PWK_EVENT_PULSE_MS * (PWK_CLK_HZ / 1000);

    // register byte offsets
    localparam logic [7:0] PWK_OFF_POWER_CTRL = 8'h00;
    localparam logic [7:0] PWK_OFF_INTERRUPT_STATUS_REG = 8'h04;
    localparam logic [7:0] PWK_OFF_INT_EN = 8'h08;
    localparam logic [7:0] PWK_OFF_WAKE = 8'h0C;
    localparam logic [7:0] PWK_OFF_PHY_CTRL = 8'h10;

    // power_control_reg fields
    localparam int PWK_PC_READY_BIT = 0;
    localparam int PWK_PC_EVENT_EN_BIT = 1;
    localparam int PWK_PC_PULSE_SEL_BIT = 2;
    localparam int PWK_PC_WAKE_LAN_ENABLE_BIT = 3;
    localparam int PWK_PC_ENERGY_DETECT_ENABLE_BIT = 4;
    localparam int PWK_PC_WSRC_LSB = 5;
    localparam int PWK_PC_MODE_LSB = 12;

    // interrupt_status_reg and enable fields
    localparam int PWK_IS_EVENT_BIT = 0;
    localparam int PWK_IS_ENERGY_BIT = 1;

    // phy control register fields
    localparam int PWK_PHY_GEN_PD_BIT = 11;
    localparam int PWK_PHY_ED_PD_BIT = 13;

    // power_mode_field codes
    localparam logic [1:0] PWK_MODE_NORMAL = 2'h0;
    localparam logic [1:0] PWK_MODE_WAKE_LISTEN = 2'h1;
    localparam logic [1:0] PWK_MODE_ENERGY = 2'h2;

    // wake_source_status codes
    localparam logic [1:0] PWK_WSRC_NONE = 2'h0;
    localparam logic [1:0] PWK_WSRC_ENERGY = 2'h1;
    localparam logic [1:0] PWK_WSRC_FRAME = 2'h2;

    // reset values
    localparam logic PWK_READY_RST = 1'b1;
    localparam logic [1:0] PWK_INT_RST = 2'h0;

    typedef enum logic [1:0] {
        PWK_ST_NORMAL,
        PWK_ST_LISTEN,
        PWK_ST_ENERGY,
        PWK_ST_WAKING
    } pwk_state_t;

endpackage

/* pwk_power_wake.sv */
// power state controller with wake-source reporting and event signal
// assumes a host register port synchronous to sys_clk, one-cycle strobes,
// and wake/energy detector inputs synchronous to sys_clk
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - writing mode 01 enters wake-listen sleep and gates MAC and host clocks.
// - writing mode 10 enters energy-detect sleep; all clocks stop.
// - entering either sleep clears ready until return to normal completes.
// - any write to wake register in sleep returns to normal, mode 00.
// - host writes ignored after reset or wake until one read occurs.
// - entering wake-listen arms wake frame detection automatically.
// - wake frame in wake-listen drives event if wake-LAN and event enabled.
// - wake frame in wake-listen loads wake source status with 10.
// - carrier in energy-detect loads 01; event if energy and event enabled.
// - carrier already present at energy-detect entry is reported at once.
// - power event sets event status bit regardless of event enable.
// - internal event interrupt holds until source status or enable cleared.
// - writing 1 clears event status once internal interrupt is gone.
// - pulse select set drives event output for 50 ms then releases.
// - pulse select clear holds event output until deactivated.
// - clearing source status, source enable or event enable drops event.
// - general PHY powerdown bit holds PHY down; clearing it resets PHY.
// - energy powerdown with no line energy powers PHY down, no transmit.
// - line energy powers PHY up and sets PHY energy interrupt flag.
// - ready sets 2 ms after the clock edge that takes the waking write.
module pwk_power_wake
    import pwk_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 32,
    parameter int unsigned READY_DELAY_CYC = PWK_WAKE_READY_CYC,
    parameter int unsigned EVENT_PULSE_CYC = PWK_EVENT_PULSE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic wake_frame_det,
    input wire logic line_energy_present,
    output logic ready,
    output logic mac_host_clk_en,
    output logic internal_clk_en,
    output logic rx_wake_armed,
    output logic event_out,
    output logic host_irq,
    output logic phy_power_down,
    output logic phy_tx_enable,
    output logic phy_auto_reset
);

    pwk_state_t state_q;
    pwk_state_t state_d;
    logic ready_q;
    logic ready_d;
    logic read_seen_q;
    logic [31:0] wake_cnt_q;
    logic [31:0] wake_cnt_d;
    logic event_en_q;
    logic pulse_sel_q;
    logic wake_lan_enable_q;
    logic energy_detect_enable_q;
    logic [1:0] wsrc_q;
    logic [1:0] wsrc_d;
    logic [1:0] interrupt_status_reg_q;
    logic [1:0] interrupt_status_reg_d;
    logic [1:0] int_en_q;
    logic gen_pd_q;
    logic ed_pd_q;
    logic energy_q;
    logic event_active_q;
    logic [31:0] pulse_cnt_q;
    logic [31:0] pulse_cnt_d;
    logic [DW-1:0] rdata_q;
    logic clk_en_q;
    logic int_clk_en_q;
    logic armed_q;
    logic event_q;
    logic irq_q;
    logic phy_pd_q;
    logic phy_tx_q;
    logic phy_rst_q;

    // address decode
    wire sel_pc = (reg_addr == AW'(PWK_OFF_POWER_CTRL));
    wire sel_is = (reg_addr == AW'(PWK_OFF_INTERRUPT_STATUS_REG));
    wire sel_ie = (reg_addr == AW'(PWK_OFF_INT_EN));
    wire sel_wake = (reg_addr == AW'(PWK_OFF_WAKE));
    wire sel_phy = (reg_addr == AW'(PWK_OFF_PHY_CTRL));

    wire sleeping = (state_q == PWK_ST_LISTEN) || (state_q == PWK_ST_ENERGY);
    wire awake = (state_q == PWK_ST_NORMAL) && ready_q;

    // ordinary writes need a prior read and a fully awake device
    wire wr_ok = reg_wr && read_seen_q && awake;
    wire pc_wr = wr_ok && sel_pc;
    wire is_wr = wr_ok && sel_is;
    wire ie_wr = wr_ok && sel_ie;
    wire phy_wr = wr_ok && sel_phy;
    wire wake_wr = reg_wr && sel_wake && sleeping;

    wire [1:0] wr_mode = reg_wdata[PWK_PC_MODE_LSB +: 2];
    wire [1:0] wr_wsrc_clr = reg_wdata[PWK_PC_WSRC_LSB +: 2];

    // wake detection, armed only in the matching sleep state
    wire detect_frame = (state_q == PWK_ST_LISTEN) && wake_frame_det;
    // level sampled every cycle so a carrier at entry is seen at once
    wire detect_energy = (state_q == PWK_ST_ENERGY) &&
        line_energy_present;

    // internal event interrupt follows source status and its enable
    wire pme_int = (wsrc_q[1] && wake_lan_enable_q) ||
        (wsrc_q[0] && energy_detect_enable_q);
    wire event_active = pme_int && event_en_q;
    wire event_rise = event_active && !event_active_q;

    wire energy_rise = ed_pd_q && line_energy_present && !energy_q;
    wire phy_down_now = gen_pd_q ||
        (ed_pd_q && !line_energy_present);

    wire [1:0] mode_code = (state_q == PWK_ST_LISTEN) ? PWK_MODE_WAKE_LISTEN :
        (state_q == PWK_ST_ENERGY) ? PWK_MODE_ENERGY : PWK_MODE_NORMAL;

    // register read values
    wire [DW-1:0] pc_word = (DW'(mode_code) << PWK_PC_MODE_LSB) |
        (DW'(wsrc_q) << PWK_PC_WSRC_LSB) |
        (DW'(energy_detect_enable_q) << PWK_PC_ENERGY_DETECT_ENABLE_BIT) |
        (DW'(wake_lan_enable_q) << PWK_PC_WAKE_LAN_ENABLE_BIT) |
        (DW'(pulse_sel_q) << PWK_PC_PULSE_SEL_BIT) |
        (DW'(event_en_q) << PWK_PC_EVENT_EN_BIT) |
        (DW'(ready_q) << PWK_PC_READY_BIT);
    wire [DW-1:0] phy_word = (DW'(ed_pd_q) << PWK_PHY_ED_PD_BIT) |
        (DW'(gen_pd_q) << PWK_PHY_GEN_PD_BIT);
    // while not awake only the power control register answers
    wire [DW-1:0] rd_word = sel_pc ? pc_word :
        !awake ? '0 :
        sel_is ? DW'(interrupt_status_reg_q) :
        sel_ie ? DW'(int_en_q) :
        sel_phy ? phy_word : '0;

    // state sequencing
    always_comb
    begin
        state_d = state_q;
        ready_d = ready_q;
        wake_cnt_d = wake_cnt_q;
        case (state_q)
            PWK_ST_NORMAL:
            begin
                if (pc_wr && wr_mode == PWK_MODE_WAKE_LISTEN)
                begin
                    state_d = PWK_ST_LISTEN;
                    ready_d = 1'b0;
                end
                else if (pc_wr && wr_mode == PWK_MODE_ENERGY)
                begin
                    state_d = PWK_ST_ENERGY;
                    ready_d = 1'b0;
                end
                // codes 00 and 11 keep the normal state
                else
                begin
                    state_d = PWK_ST_NORMAL;
                end
            end
            PWK_ST_LISTEN, PWK_ST_ENERGY:
            begin
                if (wake_wr)
                begin
                    state_d = PWK_ST_WAKING;
                    wake_cnt_d = READY_DELAY_CYC - 32'd1;
                end
            end
            PWK_ST_WAKING:
            begin
                if (wake_cnt_q == 32'd0)
                begin
                    state_d = PWK_ST_NORMAL;
                    ready_d = 1'b1;
                end
                else
                begin
                    wake_cnt_d = wake_cnt_q - 32'd1;
                end
            end
            default:
            begin
                state_d = PWK_ST_NORMAL;
            end
        endcase
    end

    // wake source: detection wins over a same-cycle clear
    always_comb
    begin
        wsrc_d = wsrc_q & ~(pc_wr ? wr_wsrc_clr : 2'h0);
        if (detect_frame)
        begin
            wsrc_d = PWK_WSRC_FRAME;
        end
        else if (detect_energy)
        begin
            wsrc_d = PWK_WSRC_ENERGY;
        end
    end

    // status bits: hardware set wins over write-one clear
    always_comb
    begin
        interrupt_status_reg_d = interrupt_status_reg_q & ~(is_wr ? reg_wdata[1:0] : 2'h0);
        if (pme_int)
        begin
            interrupt_status_reg_d[PWK_IS_EVENT_BIT] = 1'b1;
        end
        if (energy_rise)
        begin
            interrupt_status_reg_d[PWK_IS_ENERGY_BIT] = 1'b1;
        end
    end

    // event pulse timer
    always_comb
    begin
        pulse_cnt_d = pulse_cnt_q;
        if (!event_active)
        begin
            pulse_cnt_d = 32'd0;
        end
        else if (event_rise)
        begin
            pulse_cnt_d = EVENT_PULSE_CYC - 32'd1;
        end
        else if (pulse_cnt_q != 32'd0)
        begin
            pulse_cnt_d = pulse_cnt_q - 32'd1;
        end
    end

    wire event_d = event_active &&
        (!pulse_sel_q || event_rise || pulse_cnt_q != 32'd0);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= PWK_ST_NORMAL;
            ready_q <= PWK_READY_RST;
            wake_cnt_q <= 32'd0;
            pulse_cnt_q <= 32'd0;
            wsrc_q <= PWK_WSRC_NONE;
            interrupt_status_reg_q <= PWK_INT_RST;
            event_active_q <= 1'b0;
            energy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ready_q <= ready_d;
            wake_cnt_q <= wake_cnt_d;
            pulse_cnt_q <= pulse_cnt_d;
            wsrc_q <= wsrc_d;
            interrupt_status_reg_q <= interrupt_status_reg_d;
            event_active_q <= event_active;
            energy_q <= line_energy_present;
        end
    end

    // read-before-write guard, re-armed by the waking write
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            read_seen_q <= 1'b0;
        end
        else if (wake_wr)
        begin
            read_seen_q <= 1'b0;
        end
        else if (reg_rd)
        begin
            read_seen_q <= 1'b1;
        end
    end

    // software controls
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            event_en_q <= 1'b0;
            pulse_sel_q <= 1'b0;
            wake_lan_enable_q <= 1'b0;
            energy_detect_enable_q <= 1'b0;
        end
        else if (pc_wr)
        begin
            event_en_q <= reg_wdata[PWK_PC_EVENT_EN_BIT];
            pulse_sel_q <= reg_wdata[PWK_PC_PULSE_SEL_BIT];
            wake_lan_enable_q <= reg_wdata[PWK_PC_WAKE_LAN_ENABLE_BIT];
            energy_detect_enable_q <= reg_wdata[PWK_PC_ENERGY_DETECT_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            int_en_q <= PWK_INT_RST;
        end
        else if (ie_wr)
        begin
            int_en_q <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            gen_pd_q <= 1'b0;
            ed_pd_q <= 1'b0;
        end
        else if (phy_wr)
        begin
            gen_pd_q <= reg_wdata[PWK_PHY_GEN_PD_BIT];
            ed_pd_q <= reg_wdata[PWK_PHY_ED_PD_BIT];
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
            clk_en_q <= 1'b1;
            int_clk_en_q <= 1'b1;
            armed_q <= 1'b0;
            event_q <= 1'b0;
            irq_q <= 1'b0;
            phy_pd_q <= 1'b0;
            phy_tx_q <= 1'b1;
            phy_rst_q <= 1'b0;
        end
        else
        begin
            rdata_q <= reg_rd ? rd_word : '0;
            clk_en_q <= (state_d == PWK_ST_NORMAL);
            int_clk_en_q <= (state_d != PWK_ST_ENERGY);
            armed_q <= (state_d == PWK_ST_LISTEN);
            event_q <= event_d;
            irq_q <= |(interrupt_status_reg_q & int_en_q);
            phy_pd_q <= phy_down_now;
            phy_tx_q <= !phy_down_now;
            phy_rst_q <= phy_wr && gen_pd_q &&
                !reg_wdata[PWK_PHY_GEN_PD_BIT];
        end
    end

    assign reg_rdata = rdata_q;
    assign ready = ready_q;
    assign mac_host_clk_en = clk_en_q;
    assign internal_clk_en = int_clk_en_q;
    assign rx_wake_armed = armed_q;
    assign event_out = event_q;
    assign host_irq = irq_q;
    assign phy_power_down = phy_pd_q;
    assign phy_tx_enable = phy_tx_q;
    assign phy_auto_reset = phy_rst_q;

endmodule

`default_nettype wire

/* pwk_pkg_unused_guard.sv */
// empty source unit of the power state block, holds no logic
// assumes nothing of its surroundings
`default_nettype none
`default_nettype wire

/* pwk_power_wake_assertions.sv */
// checker for the power state block, bound to the ports of its top module
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module pwk_power_wake_chk
    import pwk_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 32,
    parameter int unsigned READY_DELAY_CYC = 8
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic ready,
    input wire logic mac_host_clk_en,
    input wire logic internal_clk_en,
    input wire logic rx_wake_armed,
    input wire logic phy_power_down,
    input wire logic phy_tx_enable,
    input wire logic phy_auto_reset
);
    localparam int RDLIM = int'(READY_DELAY_CYC) + 1;
    wire logic [1:0] wr_mode = reg_wdata[PWK_PC_MODE_LSB+:2];
    wire logic pc_sel = reg_addr == AW'(PWK_OFF_POWER_CTRL);
    wire logic pc_wr = reg_wr && pc_sel;
    wire logic sleep_wr = pc_wr && (wr_mode == PWK_MODE_WAKE_LISTEN ||
        wr_mode == PWK_MODE_ENERGY);
    wire logic wake_wr = reg_wr && reg_addr == AW'(PWK_OFF_WAKE);
    wire logic phy_wr = reg_wr && reg_addr == AW'(PWK_OFF_PHY_CTRL);
    wire logic sleeping = !ready && (rx_wake_armed || !internal_clk_en);
    wire logic rd_blocked = reg_rd && !ready && !pc_sel;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_wake_req;
        sleeping && wake_wr;
    endsequence
    sequence s_ready_back;
        !ready ##[1:RDLIM] ready;
    endsequence

    AST_WAKE_READY:
        assert property (s_wake_req |=> s_ready_back)
        else $error("ready not restored after wake write");
    AST_CLK_READY:
        assert property (ready == mac_host_clk_en)
        else $error("host clock enable differs from ready");
    AST_ARMED:
        assert property (rx_wake_armed |-> !mac_host_clk_en && internal_clk_en)
        else $error("wake detection armed outside wake-listen");
    AST_ENERGY_CLK:
        assert property (!internal_clk_en |->
            !mac_host_clk_en && !rx_wake_armed)
        else $error("clocks running in energy-detect state");
    AST_SLEEP_ENTRY:
        assert property ($fell(ready) |-> $past(sleep_wr) || $past(sleep_wr, 2))
        else $error("ready fell without a sleep mode write");
    AST_WAKE_IGNORED:
        assert property (wake_wr && ready |=> ready)
        else $error("wake write outside sleep changed ready");
    AST_MODE_STAY:
        assert property (pc_wr && ready && !sleep_wr |=> ready)
        else $error("normal or reserved mode write left normal state");
    AST_PHY_TX:
        assert property (phy_tx_enable == !phy_power_down)
        else $error("phy transmits while powered down");
    AST_AUTO_RESET:
        assert property (phy_auto_reset |->
            ($past(phy_wr) || $past(phy_wr, 2)) ##1 !phy_auto_reset)
        else $error("phy auto reset without a phy write or too long");
    AST_RD_GUARD:
        assert property ($past(rd_blocked) |-> reg_rdata == '0)
        else $error("register other than power control read while not ready");
endmodule

bind pwk_power_wake pwk_power_wake_chk #(
    .AW(AW),
    .DW(DW),
    .READY_DELAY_CYC(READY_DELAY_CYC)
) i_chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ready(ready),
    .mac_host_clk_en(mac_host_clk_en),
    .internal_clk_en(internal_clk_en),
    .rx_wake_armed(rx_wake_armed),
    .phy_power_down(phy_power_down),
    .phy_tx_enable(phy_tx_enable),
    .phy_auto_reset(phy_auto_reset)
);
`default_nettype wire

/* pwk_host_model.sv */
// host cpu model: one-cycle read and write strobes on the register port
// assumes read data stand only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module pwk_host_model
(
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released lines show the inverse so stale values are never mistaken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench for the power state and wake block
// assumes the host model and checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb
    import pwk_pkg::*;
;
    localparam int unsigned RDY = 8;
    localparam int unsigned PLS = 10;
    localparam logic [31:0] EV = 32'h2;
    localparam logic [31:0] PS = 32'h4;
    localparam logic [31:0] WOL = 32'h8;
    localparam logic [31:0] ED = 32'h10;
    localparam logic [31:0] PCM = 32'h3FFF;
    localparam logic [7:0] PC = PWK_OFF_POWER_CTRL;
    localparam logic [7:0] IS = PWK_OFF_INTERRUPT_STATUS_REG;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wake_frame_det = 1'b0;
    logic line_energy_present = 1'b0;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, ready, mac_host_clk_en, internal_clk_en;
    logic rx_wake_armed, event_out, host_irq, phy_power_down;
    logic phy_tx_enable, phy_auto_reset;
    int n_errors = 0;
    int n_tests = 0;
    wire logic [3:0] pst = {ready, mac_host_clk_en, rx_wake_armed,
        internal_clk_en};

    always #12.5 sys_clk = ~sys_clk;

    pwk_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    pwk_power_wake #(.READY_DELAY_CYC(RDY), .EVENT_PULSE_CYC(PLS)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_frame_det(wake_frame_det),
        .line_energy_present(line_energy_present), .ready(ready),
        .mac_host_clk_en(mac_host_clk_en), .internal_clk_en(internal_clk_en),
        .rx_wake_armed(rx_wake_armed), .event_out(event_out),
        .host_irq(host_irq), .phy_power_down(phy_power_down),
        .phy_tx_enable(phy_tx_enable), .phy_auto_reset(phy_auto_reset));

    task automatic give_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_ready(output int n);
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (ready !== 1'b1)
        begin
            n_errors++;
            give_verdict();
        end
    endtask
    task automatic chk_rd(input string nm, input logic [7:0] a,
        input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        i_host.rd(a, d);
        `CHK(nm, e, d & m)
    endtask
    task automatic chk_out();
        `CHK("reset outs", 9'h1A2, {pst, event_out, host_irq, phy_power_down,
            phy_tx_enable, phy_auto_reset})
    endtask
    task automatic t_guard();
        i_host.wr(PC, EV);
        chk_rd("pc guard", PC, 32'h1, PCM);
        i_host.wr(PC, EV | 32'h3000);
        chk_rd("pc rsvd", PC, 32'h1 | EV, PCM);
        chk_rd("unmapped", 8'h20, 32'h0, 32'hFFFFFFFF);
        i_host.wr(PWK_OFF_WAKE, 32'h0);
        cyc(1);
        `CHK("wake normal", 4'hD, pst)
    endtask
    task automatic t_listen();
        int n;
        chk_rd("is rst", IS, 32'h0, 32'h3);
        i_host.wr(PWK_OFF_INT_EN, 32'h1);
        i_host.wr(PC, EV | WOL | 32'h1000);
        cyc(1);
        `CHK("listen", 4'h3, pst)
        chk_rd("is sleep", IS, 32'h0, 32'hFFFFFFFF);
        chk_rd("pc sleep", PC, EV | WOL | 32'h1000, PCM);
        i_host.wr(PWK_OFF_INT_EN, 32'h0);
        @(posedge sys_clk);
        wake_frame_det <= 1'b1;
        @(posedge sys_clk);
        wake_frame_det <= 1'b0;
        cyc(3);
        `CHK("ev frame", 1'b1, event_out)
        `CHK("irq frame", 1'b1, host_irq)
        i_host.wr(PWK_OFF_WAKE, 32'h0);
        wait_ready(n);
        `CHK("wake time", 1'b1, n <= RDY + 2)
        chk_rd("pc wake", PC, 32'h1 | EV | WOL | 32'h40, PCM);
        `CHK("ev static", 1'b1, event_out)
        i_host.wr(IS, 32'h1);
        chk_rd("is held", IS, 32'h1, 32'h1);
        i_host.wr(PC, EV | WOL | 32'h60);
        cyc(1);
        `CHK("ev clear", 1'b0, event_out)
        i_host.wr(IS, 32'h0);
        chk_rd("is w0", IS, 32'h1, 32'h1);
        i_host.wr(IS, 32'h1);
        chk_rd("is w1", IS, 32'h0, 32'h1);
    endtask
    task automatic t_energy();
        int n;
        int hi;
        i_host.wr(PWK_OFF_PHY_CTRL, 32'h2000);
        cyc(2);
        `CHK("ed pd", 2'h2, {phy_power_down, phy_tx_enable})
        @(posedge sys_clk);
        line_energy_present <= 1'b1;
        cyc(3);
        `CHK("ed up", 1'b0, phy_power_down)
        chk_rd("is energy", IS, 32'h2, 32'h2);
        i_host.wr(PC, EV | PS | ED | 32'h2000);
        cyc(1);
        `CHK("energy", 4'h0, pst)
        n = 0;
        while (event_out !== 1'b1 && n < 20)
        begin
            cyc(1);
            n++;
        end
        hi = 0;
        while (event_out === 1'b1 && hi < 100)
        begin
            cyc(1);
            hi++;
        end
        `CHK("pulse len", PLS, hi)
        i_host.wr(PWK_OFF_WAKE, 32'h0);
        wait_ready(n);
        chk_rd("pc energy", PC, 32'h21 | EV | PS | ED, PCM);
        i_host.wr(PWK_OFF_PHY_CTRL, 32'h0);
    endtask
    task automatic t_phy();
        int k;
        i_host.wr(PWK_OFF_PHY_CTRL, 32'h800);
        cyc(2);
        `CHK("gen pd", 1'b1, phy_power_down)
        i_host.wr(PWK_OFF_PHY_CTRL, 32'h0);
        k = 0;
        repeat (4)
        begin
            #1;
            k += int'(phy_auto_reset === 1'b1);
            @(posedge sys_clk);
        end
        cyc(1);
        `CHK("auto reset", 1, k)
        `CHK("gen up", 1'b0, phy_power_down)
    endtask
    task automatic t_reset2();
        i_host.wr(PC, EV | 32'h1000);
        cyc(1);
        `CHK("listen2", 4'h3, pst)
        @(posedge sys_clk);
        rst <= 1'b1;
        #1;
        `CHK("async rst", 1'b1, ready)
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk_out();
    endtask

    initial
    begin
        #500000;
        n_errors++;
        give_verdict();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk_out();
        t_guard();
        t_listen();
        t_energy();
        t_phy();
        t_reset2();
        give_verdict();
    end
endmodule
`default_nettype wire
